// ### oag_mem_model.sv
`timescale 1ns/1ps

module oag_mem_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // read port
   input wire logic mem_rd_req,
   input wire logic [15:0] mem_addr,
   output logic mem_rd_ack,
   output logic [15:0] mem_rd_data,
   // answer delay in cycles, 0 answers in the cycle the request shows
   input wire logic [3:0] lat
);
   logic [3:0] wait_reg;
   logic [15:0] last_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // every word reads back as its own address plus 0100h
   assign mem_rd_ack = mem_rd_req && (wait_reg == lat);
   // outside an answer the data lines show the inverse of the last word, so a stale capture is caught
   assign mem_rd_data = mem_rd_ack ? mem_addr + 16'h0100 : ~last_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wait_reg <= 4'h0;
         last_reg <= 16'h0000;
      end else if (mem_rd_ack) begin
         wait_reg <= 4'h0;
         last_reg <= mem_rd_data;
      end else if (mem_rd_req) begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// ### oag_operand_address_generator.sv
// Functional notes
// - register seven is the program counter
// - each word fetch via PC adds two
// - byte operations still step PC by two
// - immediate is autoincrement on the PC
// - absolute is autoincrement deferred on PC
// - relative is index on the updated PC
// - relative base equals instruction address plus four
// - relative deferred reads pointer at PC-relative sum
// - mode one uses register as address
// - mode two uses then increments register
// - mode three pointer, then increment two
// - mode four decrements then uses register
// - mode five decrements two, then pointer
// - index adds next word to register
// - index deferred reads pointer at sum
// - low mode bit selects deferred form
// - source bits 11-6, destination bits 5-0
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_operand_address_generator (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // request from instruction decode
   input wire logic start,
   input wire oag_pkg::oag_req_t req,
   // result
   output oag_pkg::oag_result_t result,
   output logic done,
   output logic busy,
   // memory read port for extension words and pointers
   output logic mem_rd_req,
   output logic [15:0] mem_addr,
   input wire logic mem_rd_ack,
   input wire logic [15:0] mem_rd_data,
   // general register access from the rest of the cpu
   input wire logic reg_wr_en,
   input wire logic [2:0] reg_wr_sel,
   input wire logic [15:0] reg_wr_data,
   input wire logic [2:0] reg_rd_sel,
   output logic [15:0] reg_rd_data,
   output logic [15:0] pc_value
);
   import oag_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] gr_reg [0:7];
   oag_state_t state_reg;
   logic [2:0] mode_reg;
   logic [2:0] sel_reg;
   logic [15:0] index_reg;
   logic [5:0] field;
   logic [2:0] cur_mode;
   logic [2:0] cur_sel;
   logic [15:0] base;
   logic [15:0] step;
   logic [15:0] index_sum;
   logic upd_en;
   logic [2:0] upd_sel;
   logic [15:0] upd_val;
   logic go;

   assign go = start && (state_reg == ST_IDLE);
   // source and destination fields decode independently
   assign field = req.src_sel ? req.instr[`OAG_SRC_LSB +: 6] : req.instr[`OAG_DST_LSB +: 6];
   assign cur_mode = (state_reg == ST_IDLE) ? field[5:3] : mode_reg;
   assign cur_sel = (state_reg == ST_IDLE) ? field[2:0] : sel_reg;
   // register seven is read from the same file, so pc modes fall out of the general ones
   assign base = gr_reg[cur_sel];
   // byte step only for r0-r5 in the non-deferred auto modes
   assign step = (req.byte_op && cur_sel < `OAG_SP_IDX && !cur_mode[0]) ? `OAG_STEP_BYTE
                 : `OAG_STEP_WORD;
   // pc has already stepped past the index word here, giving instruction address plus four
   assign index_sum = base + index_reg;

   ////////////////////////////////////////////////////////////////////////
   // register update requested by the generator
   always_comb begin
      upd_en = 1'b0;
      upd_sel = cur_sel;
      upd_val = base;
      if (go) begin
         case (cur_mode)
            `OAG_MODE_AUTOINC: begin
               upd_en = 1'b1;
               upd_val = base + step;
            end
            `OAG_MODE_AUTOINC_DEF: begin
               upd_en = 1'b1;
               upd_val = base + `OAG_STEP_WORD;
            end
            `OAG_MODE_AUTODEC: begin
               upd_en = 1'b1;
               upd_val = base - step;
            end
            `OAG_MODE_AUTODEC_DEF: begin
               upd_en = 1'b1;
               upd_val = base - `OAG_STEP_WORD;
            end
            default: begin
               upd_en = 1'b0;
            end
         endcase
      end else if (state_reg == ST_INDEX_FETCH && mem_rd_ack) begin
         upd_en = 1'b1;
         upd_sel = `OAG_PC_IDX;
         upd_val = gr_reg[`OAG_PC_IDX] + `OAG_STEP_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general registers; the generator's own update wins over an outside write
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_gr
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               gr_reg[gi] <= `OAG_REG_RESET;
            end else if (upd_en && upd_sel == 3'(gi)) begin
               gr_reg[gi] <= upd_val;
            end else if (reg_wr_en && reg_wr_sel == 3'(gi)) begin
               gr_reg[gi] <= reg_wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rd_data <= `OAG_REG_RESET;
         pc_value <= `OAG_REG_RESET;
      end else begin
         reg_rd_data <= gr_reg[reg_rd_sel];
         pc_value <= (upd_en && upd_sel == `OAG_PC_IDX) ? upd_val : gr_reg[`OAG_PC_IDX];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         mode_reg <= `OAG_MODE_REG;
         sel_reg <= 3'h0;
         index_reg <= `OAG_REG_RESET;
         result <= '0;
         done <= 1'b0;
         busy <= 1'b0;
         mem_rd_req <= 1'b0;
         mem_addr <= `OAG_REG_RESET;
      end else begin
         done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (go) begin
                  mode_reg <= cur_mode;
                  sel_reg <= cur_sel;
                  result.reg_num <= cur_sel;
                  result.in_reg <= (cur_mode == `OAG_MODE_REG);
                  case (cur_mode)
                     `OAG_MODE_REG: begin
                        result.ea <= 16'h0000;
                        done <= 1'b1;
                     end
                     `OAG_MODE_REG_DEF, `OAG_MODE_AUTOINC: begin
                        result.ea <= base;
                        done <= 1'b1;
                     end
                     `OAG_MODE_AUTODEC: begin
                        result.ea <= base - step;
                        done <= 1'b1;
                     end
                     `OAG_MODE_AUTOINC_DEF: begin
                        mem_addr <= base;
                        mem_rd_req <= 1'b1;
                        busy <= 1'b1;
                        state_reg <= ST_POINTER;
                     end
                     `OAG_MODE_AUTODEC_DEF: begin
                        mem_addr <= base - `OAG_STEP_WORD;
                        mem_rd_req <= 1'b1;
                        busy <= 1'b1;
                        state_reg <= ST_POINTER;
                     end
                     default: begin
                        mem_addr <= gr_reg[`OAG_PC_IDX];
                        mem_rd_req <= 1'b1;
                        busy <= 1'b1;
                        state_reg <= ST_INDEX_FETCH;
                     end
                  endcase
               end
            end
            ST_INDEX_FETCH: begin
               if (mem_rd_ack) begin
                  index_reg <= mem_rd_data;
                  mem_rd_req <= 1'b0;
                  state_reg <= ST_INDEX_ADD;
               end
            end
            ST_INDEX_ADD: begin
               // low mode bit turns the sum into a pointer
               if (mode_reg[0]) begin
                  mem_addr <= index_sum;
                  mem_rd_req <= 1'b1;
                  state_reg <= ST_POINTER;
               end else begin
                  result.ea <= index_sum;
                  done <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_POINTER: begin
               if (mem_rd_ack) begin
                  result.ea <= mem_rd_data;
                  mem_rd_req <= 1'b0;
                  done <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_pc_autoinc;
      @(posedge ref_clk) disable iff (reset)
      (go && cur_sel == `OAG_PC_IDX && cur_mode == `OAG_MODE_AUTOINC)
      |=> (pc_value == $past(base) + 16'h0002) && done && result.ea == $past(base);
   endproperty
   a_pc_autoinc: assert property (p_pc_autoinc) else $error("pc immediate step wrong");
   property p_pc_byte_step;
      @(posedge ref_clk) disable iff (reset)
      (go && req.byte_op && cur_sel == `OAG_PC_IDX && cur_mode == `OAG_MODE_AUTOINC)
      |=> gr_reg[`OAG_PC_IDX] == $past(base) + 16'h0002;
   endproperty
   a_pc_byte_step: assert property (p_pc_byte_step) else $error("byte op stepped pc by one");
   property p_byte_autoinc;
      @(posedge ref_clk) disable iff (reset)
      (go && req.byte_op && cur_sel == 3'h0 && cur_mode == `OAG_MODE_AUTOINC && !reg_wr_en)
      |=> gr_reg[0] == $past(base) + 16'h0001;
   endproperty
   a_byte_autoinc: assert property (p_byte_autoinc) else $error("byte autoincrement not by one");
   property p_word_autodec;
      @(posedge ref_clk) disable iff (reset)
      (go && !req.byte_op && cur_mode == `OAG_MODE_AUTODEC)
      |=> done && result.ea == $past(base) - 16'h0002;
   endproperty
   a_word_autodec: assert property (p_word_autodec) else $error("autodecrement address wrong");
   property p_reg_deferred_keep;
      @(posedge ref_clk) disable iff (reset)
      (go && cur_mode == `OAG_MODE_REG_DEF && !reg_wr_en)
      |=> result.ea == $past(base) && gr_reg[$past(cur_sel)] == $past(base);
   endproperty
   a_reg_deferred_keep: assert property (p_reg_deferred_keep) else $error("register deferred changed reg");

   property p_autoinc_def_ptr;
      @(posedge ref_clk) disable iff (reset)
      (go && cur_mode == `OAG_MODE_AUTOINC_DEF)
      |=> mem_rd_req && mem_addr == $past(base) && state_reg == ST_POINTER;
   endproperty
   a_autoinc_def_ptr: assert property (p_autoinc_def_ptr) else $error("autoinc deferred pointer wrong");

   property p_autodec_def_ptr;
      @(posedge ref_clk) disable iff (reset)
      (go && cur_mode == `OAG_MODE_AUTODEC_DEF)
      |=> mem_rd_req && mem_addr == $past(base) - 16'h0002;
   endproperty
   a_autodec_def_ptr: assert property (p_autodec_def_ptr) else $error("autodec deferred pointer wrong");

   property p_index_fetch_pc;
      @(posedge ref_clk) disable iff (reset)
      (state_reg == ST_INDEX_FETCH && mem_rd_ack)
      |=> pc_value == $past(gr_reg[7]) + 16'h0002 && state_reg == ST_INDEX_ADD;
   endproperty
   a_index_fetch_pc: assert property (p_index_fetch_pc) else $error("index fetch did not step pc");

   property p_relative_ea;
      @(posedge ref_clk) disable iff (reset)
      (state_reg == ST_INDEX_ADD && mode_reg == `OAG_MODE_INDEX && sel_reg == `OAG_PC_IDX)
      |=> done && result.ea == $past(pc_value) + $past(index_reg);
   endproperty
   a_relative_ea: assert property (p_relative_ea) else $error("relative address wrong");

   property p_src_field;
      @(posedge ref_clk) disable iff (reset)
      (go && req.src_sel) |=> mode_reg == $past(req.instr[11:9]) && sel_reg == $past(req.instr[8:6]);
   endproperty
   a_src_field: assert property (p_src_field) else $error("source field decoded wrong");
endmodule

// ### oag_operand_address_generator_bench.sv
`timescale 1ns/1ps

module oag_operand_address_generator_bench;
   import oag_pkg::*;
   typedef struct packed {
      logic [5:0] fld;
      logic s;
      logic b;
      logic [15:0] rv;
      logic [15:0] ea;
      logic [15:0] ra;
      logic [15:0] pc;
   } oag_row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   oag_req_t req = '0;
   oag_result_t result;
   logic done, busy, mem_rd_req, mem_rd_ack;
   logic [15:0] mem_addr, mem_rd_data, reg_rd_data, pc_value;
   logic reg_wr_en = 1'b0;
   logic [2:0] reg_wr_sel = 3'h0;
   logic [15:0] reg_wr_data = 16'h0000;
   logic [2:0] reg_rd_sel = 3'h0;
   logic [3:0] lat = 4'h0;
   int n_fail = 0;
   int comparisons = 0;
   // field, source side, byte, start value, address, register after, pc after
   oag_row_t rows [16] = '{
      '{6'h03, 1'b0, 1'b0, 16'h1234, 16'h0000, 16'h1234, 16'h1000},
      '{6'h0D, 1'b1, 1'b0, 16'h2000, 16'h2000, 16'h2000, 16'h1000},
      '{6'h12, 1'b0, 1'b0, 16'h3000, 16'h3000, 16'h3002, 16'h1000},
      '{6'h10, 1'b1, 1'b1, 16'h3000, 16'h3000, 16'h3001, 16'h1000},
      '{6'h16, 1'b0, 1'b1, 16'h4000, 16'h4000, 16'h4002, 16'h1000},
      '{6'h17, 1'b1, 1'b1, 16'h1000, 16'h1000, 16'h1002, 16'h1002},
      '{6'h19, 1'b0, 1'b1, 16'h5000, 16'h5100, 16'h5002, 16'h1000},
      '{6'h1F, 1'b1, 1'b0, 16'h1000, 16'h1100, 16'h1002, 16'h1002},
      '{6'h20, 1'b0, 1'b1, 16'h6000, 16'h5FFF, 16'h5FFF, 16'h1000},
      '{6'h26, 1'b1, 1'b1, 16'h6000, 16'h5FFE, 16'h5FFE, 16'h1000},
      '{6'h24, 1'b0, 1'b0, 16'h0000, 16'hFFFE, 16'hFFFE, 16'h1000},
      '{6'h2B, 1'b1, 1'b1, 16'h7000, 16'h70FE, 16'h6FFE, 16'h1000},
      '{6'h34, 1'b0, 1'b0, 16'h8000, 16'h9100, 16'h8000, 16'h1002},
      '{6'h37, 1'b1, 1'b0, 16'h1000, 16'h2102, 16'h1002, 16'h1002},
      '{6'h3A, 1'b0, 1'b0, 16'hF000, 16'h0200, 16'hF000, 16'h1002},
      '{6'h3F, 1'b1, 1'b0, 16'h1000, 16'h2202, 16'h1002, 16'h1002}};

   oag_operand_address_generator i_oag_operand_address_generator (
      .ref_clk(ref_clk), .reset(reset), .start(start), .req(req), .result(result), .done(done),
      .busy(busy), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
      .reg_wr_data(reg_wr_data), .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data), .pc_value(pc_value));

   oag_mem_model i_oag_mem_model (
      .ref_clk(ref_clk), .reset(reset), .mem_rd_req(mem_rd_req), .mem_addr(mem_addr),
      .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .lat(lat));

   always #5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (n_fail == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic set_reg(input logic [2:0] r, input logic [15:0] v);
      @(negedge ref_clk);
      reg_wr_en = 1'b1;
      reg_wr_sel = r;
      reg_wr_data = v;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
   endtask

   task automatic issue(input logic [5:0] f, input logic s, input logic b);
      @(negedge ref_clk);
      start = 1'b1;
      // the unused field holds the complement, so decoding the wrong one shows
      req = '{s ? {4'hF, f, ~f} : {4'hF, ~f, f}, s, b};
      @(negedge ref_clk);
      start = 1'b0;
   endtask

   task automatic wait_done();
      for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge ref_clk);
      if (done !== 1'b1) begin
         n_fail++;
         give_verdict();
      end
   endtask

   task automatic read_reg(input logic [2:0] r, input logic [15:0] exp);
      reg_rd_sel = r;
      @(negedge ref_clk);
      @(negedge ref_clk);
      check("register", exp, reg_rd_data);
   endtask

   task automatic check_idle();
      check("flags", 16'h0000, {13'h0000, done, busy, mem_rd_req});
      check("pc", 16'h0000, pc_value);
      check("ea", 16'h0000, result.ea);
   endtask

   task automatic run_row(input oag_row_t r);
      set_reg(r.fld[2:0], r.rv);
      if (r.fld[2:0] != 3'h7) set_reg(3'h7, 16'h1000);
      issue(r.fld, r.s, r.b);
      wait_done();
      check("ea", r.ea, result.ea);
      check("in_reg", {15'h0000, r.fld[5:3] == 3'h0}, {15'h0000, result.in_reg});
      check("reg_num", {13'h0000, r.fld[2:0]}, {13'h0000, result.reg_num});
      check("pc", r.pc, pc_value);
      read_reg(r.fld[2:0], r.ra);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge ref_clk);
      check_idle();
      reset = 1'b0;
      for (int l = 0; l < 2; l++) begin
         lat = (l == 0) ? 4'h0 : 4'h3;
         foreach (rows[i]) run_row(rows[i]);
      end
      // two autoincrements taken on consecutive edges
      set_reg(3'h2, 16'h3000);
      @(negedge ref_clk);
      start = 1'b1;
      req = '{16'hF012, 1'b0, 1'b0};
      @(negedge ref_clk);
      check("ea", 16'h3000, result.ea);
      @(negedge ref_clk);
      start = 1'b0;
      check("ea", 16'h3002, result.ea);
      read_reg(3'h2, 16'h3004);
      // a start while busy is dropped and leaves its register alone
      set_reg(3'h5, 16'h2000);
      set_reg(3'h1, 16'h5000);
      issue(6'h19, 1'b0, 1'b0);
      @(negedge ref_clk);
      // the pointer read is still outstanding, so busy must stand here
      check("busy", 16'h0001, {15'h0000, busy});
      start = 1'b1;
      req = '{16'hF015, 1'b0, 1'b0};
      @(negedge ref_clk);
      start = 1'b0;
      wait_done();
      check("ea", 16'h5100, result.ea);
      read_reg(3'h5, 16'h2000);
      // reset in the middle of a deferred index cycle
      issue(6'h3A, 1'b0, 1'b0);
      @(negedge ref_clk);
      reset = 1'b1;
      @(negedge ref_clk);
      check_idle();
      reset = 1'b0;
      // first request right after release: all registers start from zero
      issue(6'h22, 1'b0, 1'b0);
      check("done", 16'h0001, {15'h0000, done});
      check("ea", 16'hFFFE, result.ea);
      read_reg(3'h2, 16'hFFFE);
      give_verdict();
   end
endmodule

// ### oag_params.svh
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// register numbering
`define OAG_PC_IDX 3'h7
`define OAG_SP_IDX 3'h6

// pointer steps
`define OAG_STEP_WORD 16'h0002
`define OAG_STEP_BYTE 16'h0001

// operand field positions inside the instruction word
`define OAG_SRC_LSB 6
`define OAG_DST_LSB 0

// mode codes
`define OAG_MODE_REG 3'h0
`define OAG_MODE_REG_DEF 3'h1
`define OAG_MODE_AUTOINC 3'h2
`define OAG_MODE_AUTOINC_DEF 3'h3
`define OAG_MODE_AUTODEC 3'h4
`define OAG_MODE_AUTODEC_DEF 3'h5
`define OAG_MODE_INDEX 3'h6
`define OAG_MODE_INDEX_DEF 3'h7

// reset values
`define OAG_REG_RESET 16'h0000

`endif

// ### oag_pkg.sv
package oag_pkg;

   typedef struct packed {
      logic [15:0] instr;
      logic src_sel;
      logic byte_op;
   } oag_req_t;

   typedef struct packed {
      logic [15:0] ea;
      logic in_reg;
      logic [2:0] reg_num;
   } oag_result_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_INDEX_FETCH,
      ST_INDEX_ADD,
      ST_POINTER
   } oag_state_t;

endpackage
